// File: src/asp_pkg.sv
// Package of offsets, field positions, reset values and carrier types for the control slice.
package asp_pkg;

	// ==========================================================
	// Serial frame layout
	// ==========================================================
	// The frame is: read flag, 3-bit page code, 4 zero bits, 8-bit offset, 8-bit data.
	localparam logic [4:0] HDR_LAST_BIT = 5'h0F;
	localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
	localparam logic [4:0] FRAME_BITS = 5'h18;

	localparam logic [2:0] PAGE_MASTER = 3'h1;
	localparam logic [2:0] PAGE_ADC = 3'h2;
	localparam logic [2:0] PAGE_DIGITAL = 3'h3;

	typedef struct packed {
		logic rd;
		logic [2:0] page;
		logic [3:0] zero;
		logic [7:0] ofs;
	} asp_hdr_t;

	// ==========================================================
	// Register offsets
	// ==========================================================
	localparam logic [7:0] OFS_COMMIT = 8'h00;
	localparam logic [7:0] OFS_PDN_SELECT = 8'h26;
	localparam logic [7:0] OFS_PERF_LOW = 8'h39;
	localparam logic [7:0] OFS_PERF_MID = 8'h3A;
	localparam logic [7:0] OFS_SYSREF_CTRL = 8'h53;
	localparam logic [7:0] OFS_MANUAL_SYSREF = 8'h54;
	localparam logic [7:0] OFS_PDN_ENABLE = 8'h55;
	localparam logic [7:0] OFS_PERF_HIGH = 8'h56;
	localparam logic [7:0] OFS_FLAG_ROUTE = 8'h59;
	localparam logic [7:0] OFS_THRESHOLD = 8'h5F;
	localparam logic [7:0] OFS_LAST = 8'hFF;
	localparam logic [7:0] OFS_FIRST_STAGED = 8'h01;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int unsigned BIT_SYSREF_IGNORE = 6;
	localparam int unsigned BIT_SYSREF_HICM = 1;
	localparam int unsigned BIT_SYSREF_SOFT = 0;
	localparam int unsigned BIT_SYSREF_MANUAL = 7;
	localparam int unsigned BIT_PDN_EN = 4;
	localparam int unsigned BIT_PDN_SELECT = 5;
	localparam int unsigned BIT_PERF_LOW_MSB = 7;
	localparam int unsigned BIT_PERF_LOW_LSB = 6;
	localparam int unsigned BIT_PERF_MID = 6;
	localparam int unsigned BIT_PERF_HIGH = 2;
	localparam int unsigned BIT_ROUTE_CHB = 7;
	localparam int unsigned BIT_ALWAYS_ONE = 5;
	localparam int unsigned BIT_PAGE_PULSE = 0;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_PERF = 4'h0;
	// Serial enable is active low, so its synchroniser resets to the idle level.
	localparam logic [4:0] RST_SYNC = 5'h10;

	typedef struct packed {
		logic sysref_ignore;
		logic sysref_high_common_mode_en;
		logic sysref_soft_level;
		logic sysref_manual_en;
		logic register_powerdown_en;
		logic powerdown_mask_select;
		logic [3:0] performance_setting;
		logic chan_b_overrange_route;
		logic always_one;
		logic [7:0] overrange_threshold_value;
		logic page_pulse;
	} asp_ctrl_t;

	localparam asp_ctrl_t RST_CTRL = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, RST_PERF,
		1'b0, 1'b0, RST_BYTE, 1'b0};

	typedef enum logic {
		WALK_IDLE = 1'b0,
		WALK_RUN = 1'b1
	} asp_walk_t;

endpackage

// File: src/asp_stage_mem.sv
// Staging memory that holds main digital page values until they are committed.
`timescale 1ns/100ps
module asp_stage_mem (
	input wire logic clk,
	input wire logic nrst,
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] raddr,
	output logic [7:0] rdata_q
);
	// ==========================================================
	// Storage
	// ==========================================================
	logic [7:0] mem [0:255];

	// Cleared at reset so that a commit never applies unknown settings.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < 256; i++) begin
				mem[i] <= asp_pkg::RST_BYTE;
			end
			rdata_q <= asp_pkg::RST_BYTE;
		end else begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata_q <= mem[raddr]; // Old data on a same-address write.
		end
	end
endmodule

// File: src/asp_ctrl_regs.sv
// Serial-port register slice for SYSREF, power-down, performance and overrange control.
// How it works
// - Ignore bit blocks the external SYSREF input.
// - Soft level bit sets internal SYSREF level.
// - Manual enable selects register SYSREF; resets low.
// - High common-mode bit drives a static output.
// - Power-down enable powers selected mask blocks.
// - Route bit puts channel B overrange on output.
// - One threshold byte serves both channels.
// - Digital page values apply only after pulse.
// - Mask select picks first or second mask.
`timescale 1ns/100ps
module asp_ctrl_regs (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic SEN_N,
	input wire logic SCLK,
	input wire logic SDIN,
	output logic SERIAL_DATA_OUT,
	input wire logic SYSREF_IN,
	input wire logic FAST_OVERRANGE_FLAG_B_IN,
	output logic SYSREF_OUT,
	output logic SYSREF_HICM,
	output logic PDN_MASK1_EN,
	output logic PDN_MASK2_EN,
	output logic [3:0] PERF_SETTING,
	output logic [7:0] FAST_OVERRANGE_FLAG_THRESHOLD,
	output logic DIG_APPLY_VALID,
	output logic [7:0] DIG_APPLY_ADDR,
	output logic [7:0] DIG_APPLY_DATA
);
	// ==========================================================
	// Helpers
	// ==========================================================
	// True when a header addresses the given page and offset.
	function automatic logic hit(input asp_pkg::asp_hdr_t h, input logic [2:0] page,
		input logic [7:0] ofs);
		hit = (h.page == page) && (h.ofs == ofs);
	endfunction

	// Read value of an addressed register; write-only bits read as zero.
	function automatic logic [7:0] read_value(input asp_pkg::asp_hdr_t h,
		input asp_pkg::asp_ctrl_t c, input logic [7:0] staged);
		logic [7:0] r;
		r = asp_pkg::RST_BYTE;
		if (hit(h, asp_pkg::PAGE_MASTER, asp_pkg::OFS_SYSREF_CTRL)) begin
			r[asp_pkg::BIT_SYSREF_IGNORE] = c.sysref_ignore;
			r[asp_pkg::BIT_SYSREF_HICM] = c.sysref_high_common_mode_en;
			r[asp_pkg::BIT_SYSREF_SOFT] = c.sysref_soft_level;
		end else if (hit(h, asp_pkg::PAGE_MASTER, asp_pkg::OFS_MANUAL_SYSREF)) begin
			r[asp_pkg::BIT_SYSREF_MANUAL] = c.sysref_manual_en;
		end else if (hit(h, asp_pkg::PAGE_MASTER, asp_pkg::OFS_PDN_ENABLE)) begin
			r[asp_pkg::BIT_PDN_EN] = c.register_powerdown_en;
		end else if (hit(h, asp_pkg::PAGE_MASTER, asp_pkg::OFS_PDN_SELECT)) begin
			r[asp_pkg::BIT_PDN_SELECT] = c.powerdown_mask_select;
		end else if (hit(h, asp_pkg::PAGE_MASTER, asp_pkg::OFS_PERF_LOW)) begin
			r[asp_pkg::BIT_PERF_LOW_MSB] = c.performance_setting[1];
			r[asp_pkg::BIT_PERF_LOW_LSB] = c.performance_setting[0];
		end else if (hit(h, asp_pkg::PAGE_MASTER, asp_pkg::OFS_PERF_MID)) begin
			r[asp_pkg::BIT_PERF_MID] = c.performance_setting[2];
		end else if (hit(h, asp_pkg::PAGE_MASTER, asp_pkg::OFS_FLAG_ROUTE)) begin
			r[asp_pkg::BIT_ALWAYS_ONE] = c.always_one;
		end else if (hit(h, asp_pkg::PAGE_ADC, asp_pkg::OFS_THRESHOLD)) begin
			r = c.overrange_threshold_value;
		end else if (hit(h, asp_pkg::PAGE_DIGITAL, asp_pkg::OFS_COMMIT)) begin
			r[asp_pkg::BIT_PAGE_PULSE] = c.page_pulse;
		end else if (h.page == asp_pkg::PAGE_DIGITAL) begin
			r = staged;
		end
		read_value = r;
	endfunction

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic sclk_prev_q;
	logic sen_n_s;
	logic sclk_s;
	logic sdin_s;
	logic sysref_s;
	logic fast_overrange_flag_s;

	// Every pin passes two flops; the first stage feeds only the second.
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			sync1_q <= asp_pkg::RST_SYNC;
			sync2_q <= asp_pkg::RST_SYNC;
			sclk_prev_q <= 1'b0;
		end else begin
			sync1_q <= {SEN_N, SCLK, SDIN, SYSREF_IN, FAST_OVERRANGE_FLAG_B_IN};
			sync2_q <= sync1_q;
			sclk_prev_q <= sync2_q[3];
		end
	end

	// Named views of the second stage.
	assign sen_n_s = sync2_q[4];
	assign sclk_s = sync2_q[3];
	assign sdin_s = sync2_q[2];
	assign sysref_s = sync2_q[1];
	assign fast_overrange_flag_s = sync2_q[0];

	// ==========================================================
	// Serial frame engine
	// ==========================================================
	logic [4:0] cnt_q, cnt_d;
	logic [23:0] sh_q, sh_d;
	logic [7:0] tx_q, tx_d;
	logic rd_act_q, rd_act_d;
	logic rd_pend_q, rd_pend_d;
	logic sdo_q, sdo_d;
	logic rise;
	logic fall;
	logic rd_req;
	logic wr_stb;
	logic [23:0] sh_in;
	asp_pkg::asp_hdr_t rd_hdr;
	asp_pkg::asp_hdr_t wr_hdr;
	asp_pkg::asp_ctrl_t ctrl_q, ctrl_d;
	logic [7:0] mem_rdata;

	assign rise = sclk_s && !sclk_prev_q && !sen_n_s;
	assign fall = !sclk_s && sclk_prev_q && !sen_n_s;
	assign sh_in = {sh_q[22:0], sdin_s};
	assign rd_hdr = asp_pkg::asp_hdr_t'(sh_in[15:0]);
	assign wr_hdr = asp_pkg::asp_hdr_t'(sh_in[23:8]);
	// A read is requested once the header is in; a write is taken on the last bit.
	assign rd_req = rise && (cnt_q == asp_pkg::HDR_LAST_BIT) && rd_hdr.rd;
	assign wr_stb = rise && (cnt_q == asp_pkg::FRAME_LAST_BIT) && !wr_hdr.rd;

	// Shift in on SCLK rise, shift out on SCLK fall; bits past the frame are ignored.
	always_comb begin
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		rd_act_d = rd_act_q;
		rd_pend_d = 1'b0;
		sdo_d = rd_act_q ? sdo_q : 1'b0;
		if (sen_n_s) begin
			cnt_d = 5'h00;
			rd_act_d = 1'b0;
		end else if (rise && (cnt_q != asp_pkg::FRAME_BITS)) begin
			cnt_d = cnt_q + 5'h01;
			sh_d = sh_in;
		end
		if (rd_req) begin
			rd_act_d = 1'b1;
			rd_pend_d = 1'b1;
		end
		// Staged data arrives one cycle after the request, so the load waits for it.
		if (rd_pend_q) begin
			tx_d = read_value(asp_pkg::asp_hdr_t'(sh_q[15:0]), ctrl_q, mem_rdata);
		end
		if (fall && rd_act_q && (cnt_q > asp_pkg::HDR_LAST_BIT)
			&& (cnt_q != asp_pkg::FRAME_BITS)) begin
			sdo_d = tx_q[7];
			tx_d = {tx_q[6:0], 1'b0};
		end
		if (ctrl_q.chan_b_overrange_route) begin
			sdo_d = fast_overrange_flag_s;
		end
	end

	// Frame engine state.
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			cnt_q <= 5'h00;
			sh_q <= 24'h000000;
			tx_q <= asp_pkg::RST_BYTE;
			rd_act_q <= 1'b0;
			rd_pend_q <= 1'b0;
			sdo_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			rd_act_q <= rd_act_d;
			rd_pend_q <= rd_pend_d;
			sdo_q <= sdo_d;
		end
	end

	// ==========================================================
	// Control registers
	// ==========================================================
	logic [7:0] wdat;
	logic commit_go;
	logic stage_we;

	assign wdat = sh_in[7:0];
	// Commit fires on the one-to-zero step of the page pulse bit.
	assign commit_go = wr_stb && hit(wr_hdr, asp_pkg::PAGE_DIGITAL, asp_pkg::OFS_COMMIT)
		&& ctrl_q.page_pulse && !wdat[asp_pkg::BIT_PAGE_PULSE];
	assign stage_we = wr_stb && (wr_hdr.page == asp_pkg::PAGE_DIGITAL)
		&& (wr_hdr.ofs != asp_pkg::OFS_COMMIT);

	// Reserved bits are not stored, so host values there have no effect.
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_stb) begin
			if (hit(wr_hdr, asp_pkg::PAGE_MASTER, asp_pkg::OFS_SYSREF_CTRL)) begin
				ctrl_d.sysref_ignore = wdat[asp_pkg::BIT_SYSREF_IGNORE];
				ctrl_d.sysref_high_common_mode_en = wdat[asp_pkg::BIT_SYSREF_HICM];
				ctrl_d.sysref_soft_level = wdat[asp_pkg::BIT_SYSREF_SOFT];
			end
			if (hit(wr_hdr, asp_pkg::PAGE_MASTER, asp_pkg::OFS_MANUAL_SYSREF)) begin
				ctrl_d.sysref_manual_en = wdat[asp_pkg::BIT_SYSREF_MANUAL];
			end
			if (hit(wr_hdr, asp_pkg::PAGE_MASTER, asp_pkg::OFS_PDN_ENABLE)) begin
				ctrl_d.register_powerdown_en = wdat[asp_pkg::BIT_PDN_EN];
			end
			if (hit(wr_hdr, asp_pkg::PAGE_MASTER, asp_pkg::OFS_PDN_SELECT)) begin
				ctrl_d.powerdown_mask_select = wdat[asp_pkg::BIT_PDN_SELECT];
			end
			// Each slice lands on its own; the field is only coherent once all are written.
			if (hit(wr_hdr, asp_pkg::PAGE_MASTER, asp_pkg::OFS_PERF_LOW)) begin
				ctrl_d.performance_setting[1] = wdat[asp_pkg::BIT_PERF_LOW_MSB];
				ctrl_d.performance_setting[0] = wdat[asp_pkg::BIT_PERF_LOW_LSB];
			end
			if (hit(wr_hdr, asp_pkg::PAGE_MASTER, asp_pkg::OFS_PERF_MID)) begin
				ctrl_d.performance_setting[2] = wdat[asp_pkg::BIT_PERF_MID];
			end
			if (hit(wr_hdr, asp_pkg::PAGE_MASTER, asp_pkg::OFS_PERF_HIGH)) begin
				ctrl_d.performance_setting[3] = wdat[asp_pkg::BIT_PERF_HIGH];
			end
			if (hit(wr_hdr, asp_pkg::PAGE_MASTER, asp_pkg::OFS_FLAG_ROUTE)) begin
				ctrl_d.chan_b_overrange_route = wdat[asp_pkg::BIT_ROUTE_CHB];
				ctrl_d.always_one = wdat[asp_pkg::BIT_ALWAYS_ONE];
			end
			if (hit(wr_hdr, asp_pkg::PAGE_ADC, asp_pkg::OFS_THRESHOLD)) begin
				ctrl_d.overrange_threshold_value = wdat;
			end
			if (hit(wr_hdr, asp_pkg::PAGE_DIGITAL, asp_pkg::OFS_COMMIT)) begin
				ctrl_d.page_pulse = wdat[asp_pkg::BIT_PAGE_PULSE];
			end
		end
	end

	// Control register state.
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			ctrl_q <= asp_pkg::RST_CTRL;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ==========================================================
	// Digital page commit walker
	// ==========================================================
	asp_pkg::asp_walk_t walk_q, walk_d;
	logic [7:0] idx_q, idx_d;
	logic iss_q, iss_d;
	logic [7:0] iss_addr_q, iss_addr_d;
	logic [7:0] mem_raddr;
	logic app_v_q, app_v_d;
	logic [7:0] app_a_q, app_a_d;
	logic [7:0] app_d_q, app_d_d;

	// A serial read takes the memory port; the walker waits that one cycle.
	assign mem_raddr = rd_req ? rd_hdr.ofs : idx_q;

	// After a commit every staged offset is replayed once, in rising order.
	always_comb begin
		walk_d = walk_q;
		idx_d = idx_q;
		iss_d = 1'b0;
		iss_addr_d = iss_addr_q;
		app_v_d = iss_q;
		app_a_d = iss_q ? iss_addr_q : app_a_q;
		app_d_d = iss_q ? mem_rdata : app_d_q;
		unique case (walk_q)
			asp_pkg::WALK_IDLE: begin
			end
			asp_pkg::WALK_RUN: begin
				if (!rd_req) begin
					iss_d = 1'b1;
					iss_addr_d = idx_q;
					idx_d = idx_q + 8'h01;
					if (idx_q == asp_pkg::OFS_LAST) begin
						walk_d = asp_pkg::WALK_IDLE;
					end
				end
			end
		endcase
		// A new commit restarts the replay so the latest values win.
		if (commit_go) begin
			walk_d = asp_pkg::WALK_RUN;
			idx_d = asp_pkg::OFS_FIRST_STAGED;
		end
	end

	// Walker state.
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			walk_q <= asp_pkg::WALK_IDLE;
			idx_q <= asp_pkg::OFS_FIRST_STAGED;
			iss_q <= 1'b0;
			iss_addr_q <= asp_pkg::RST_BYTE;
			app_v_q <= 1'b0;
			app_a_q <= asp_pkg::RST_BYTE;
			app_d_q <= asp_pkg::RST_BYTE;
		end else begin
			walk_q <= walk_d;
			idx_q <= idx_d;
			iss_q <= iss_d;
			iss_addr_q <= iss_addr_d;
			app_v_q <= app_v_d;
			app_a_q <= app_a_d;
			app_d_q <= app_d_d;
		end
	end

	asp_stage_mem u_stage (
		.clk(CLOCK),
		.nrst(NRST),
		.we(stage_we),
		.waddr(wr_hdr.ofs),
		.wdata(wdat),
		.raddr(mem_raddr),
		.rdata_q(mem_rdata)
	);

	// ==========================================================
	// Static and SYSREF outputs
	// ==========================================================
	logic sysref_out_q, sysref_out_d;
	logic pdn1_q, pdn1_d;
	logic pdn2_q, pdn2_d;

	// Manual mode overrides the pin path; the pin path costs three cycles of latency.
	always_comb begin
		if (ctrl_q.sysref_manual_en) begin
			sysref_out_d = ctrl_q.sysref_soft_level;
		end else begin
			sysref_out_d = sysref_s && !ctrl_q.sysref_ignore;
		end
		pdn1_d = ctrl_q.register_powerdown_en && !ctrl_q.powerdown_mask_select;
		pdn2_d = ctrl_q.register_powerdown_en && ctrl_q.powerdown_mask_select;
	end

	// Output flops.
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			sysref_out_q <= 1'b0;
			pdn1_q <= 1'b0;
			pdn2_q <= 1'b0;
		end else begin
			sysref_out_q <= sysref_out_d;
			pdn1_q <= pdn1_d;
			pdn2_q <= pdn2_d;
		end
	end

	assign SYSREF_OUT = sysref_out_q;
	assign SYSREF_HICM = ctrl_q.sysref_high_common_mode_en;
	assign PDN_MASK1_EN = pdn1_q;
	assign PDN_MASK2_EN = pdn2_q;
	assign PERF_SETTING = ctrl_q.performance_setting;
	assign FAST_OVERRANGE_FLAG_THRESHOLD = ctrl_q.overrange_threshold_value;
	assign SERIAL_DATA_OUT = sdo_q;
	assign DIG_APPLY_VALID = app_v_q;
	assign DIG_APPLY_ADDR = app_a_q;
	assign DIG_APPLY_DATA = app_d_q;
endmodule

// File: sim/asp_ctrl_regs_props.sv
// Port-level checker for the control slice, bound to its top module.
`timescale 1ns/100ps
module asp_ctrl_regs_props (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic SEN_N,
	input wire logic SCLK,
	input wire logic SDIN,
	input wire logic SERIAL_DATA_OUT,
	input wire logic SYSREF_IN,
	input wire logic FAST_OVERRANGE_FLAG_B_IN,
	input wire logic SYSREF_OUT,
	input wire logic SYSREF_HICM,
	input wire logic PDN_MASK1_EN,
	input wire logic PDN_MASK2_EN,
	input wire logic [3:0] PERF_SETTING,
	input wire logic [7:0] FAST_OVERRANGE_FLAG_THRESHOLD,
	input wire logic DIG_APPLY_VALID,
	input wire logic [7:0] DIG_APPLY_ADDR,
	input wire logic [7:0] DIG_APPLY_DATA
);
	logic [2:0] idle_d;
	logic [2:0] idle_q;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!NRST);

	// ==========================================================
	// Idle counter
	// ==========================================================
	// Counts cycles with the enable high, saturating at seven.
	always_comb begin
		idle_d = idle_q;
		if (SEN_N == 1'b0) begin
			idle_d = 3'h0;
		end else if (idle_q != 3'h7) begin
			idle_d = idle_q + 3'h1;
		end
	end
	// Reset clears it, so a pin edge right after reset is never judged early.
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			idle_q <= 3'h0;
		end else begin
			idle_q <= idle_d;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	a_reset_clears: assert property (disable iff (1'b0) !NRST |=> !SYSREF_OUT && !SERIAL_DATA_OUT
		&& !SYSREF_HICM && !PDN_MASK1_EN && !PDN_MASK2_EN && PERF_SETTING == 4'h0
		&& FAST_OVERRANGE_FLAG_THRESHOLD == 8'h00 && !DIG_APPLY_VALID) else $error("outputs not cleared");
	a_cfg_in_frame: assert property ($changed(SYSREF_HICM) || $changed(PDN_MASK1_EN)
		|| $changed(PDN_MASK2_EN) || $changed(PERF_SETTING) || $changed(FAST_OVERRANGE_FLAG_THRESHOLD)
		|-> idle_q < 3'h5) else $error("control output moved outside a frame");
	a_sysref_pin: assert property ($changed(SYSREF_OUT) && idle_q == 3'h7 |->
		$past(SYSREF_IN, 2) != $past(SYSREF_IN, 3) || $past(SYSREF_IN, 3) != $past(SYSREF_IN, 4))
		else $error("internal sysref moved with no pin edge");
	a_mask_exclusive: assert property (!(PDN_MASK1_EN && PDN_MASK2_EN))
		else $error("both power-down masks active");
	a_perf_step: assert property ($changed(PERF_SETTING) |->
		$countones(PERF_SETTING ^ $past(PERF_SETTING)) <= 2) else $error("perf jumped");
	a_apply_step: assert property (DIG_APPLY_VALID && $past(DIG_APPLY_VALID) |->
		DIG_APPLY_ADDR == $past(DIG_APPLY_ADDR) + 8'h01 || DIG_APPLY_ADDR == 8'h01)
		else $error("applied offsets not consecutive");
	a_apply_hold: assert property (!DIG_APPLY_VALID |-> $stable(DIG_APPLY_ADDR)
		&& $stable(DIG_APPLY_DATA)) else $error("apply bus moved between pulses");
	a_apply_nonzero: assert property (DIG_APPLY_VALID |-> DIG_APPLY_ADDR != 8'h00)
		else $error("commit offset replayed");
	c_replay_end: cover property (DIG_APPLY_VALID && DIG_APPLY_ADDR == 8'hFF);
	c_mask_two: cover property ($rose(PDN_MASK2_EN));
	c_route_high: cover property ($rose(SERIAL_DATA_OUT) && SEN_N);
endmodule

bind asp_ctrl_regs asp_ctrl_regs_props i_props (.CLOCK(CLOCK), .NRST(NRST), .SEN_N(SEN_N),
	.SCLK(SCLK), .SDIN(SDIN), .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .SYSREF_IN(SYSREF_IN), .FAST_OVERRANGE_FLAG_B_IN(FAST_OVERRANGE_FLAG_B_IN),
	.SYSREF_OUT(SYSREF_OUT), .SYSREF_HICM(SYSREF_HICM), .PDN_MASK1_EN(PDN_MASK1_EN),
	.PDN_MASK2_EN(PDN_MASK2_EN), .PERF_SETTING(PERF_SETTING), .FAST_OVERRANGE_FLAG_THRESHOLD(FAST_OVERRANGE_FLAG_THRESHOLD),
	.DIG_APPLY_VALID(DIG_APPLY_VALID), .DIG_APPLY_ADDR(DIG_APPLY_ADDR),
	.DIG_APPLY_DATA(DIG_APPLY_DATA));

// File: sim/asp_host_model.sv
// Serial configuration host that frames register reads and writes.
`timescale 1ns/100ps
module asp_host_model (
	input wire logic clk,
	output logic sen_n,
	output logic sclk,
	output logic sdin,
	input wire logic serial_data_out
);
	// ==========================================================
	// Idle levels
	// ==========================================================
	// The serial clock rests low and the enable high between frames.
	initial begin
		sen_n = 1'b1;
		sclk = 1'b0;
		sdin = 1'b0;
	end

	// ==========================================================
	// Frame task
	// ==========================================================
	// Half periods of eight clocks, twice the minimum, keep synchronised edges apart.
	// Read bits are taken just before each rise, long after the device moved them.
	task automatic xfer(input logic rd, input logic [2:0] page, input logic [7:0] ofs,
		input logic [7:0] wdata, output logic [7:0] rdata);
		asp_pkg::asp_hdr_t hdr;
		logic [23:0] frame;
		hdr = '{rd, page, 4'h0, ofs};
		frame = {hdr, wdata};
		rdata = 8'h00;
		@(posedge clk);
		sen_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sclk <= 1'b0;
			sdin <= frame[i];
			repeat (8) @(posedge clk);
			if (i < 8) begin
				rdata[i] = serial_data_out;
			end
			sclk <= 1'b1;
			repeat (8) @(posedge clk);
		end
		sen_n <= 1'b1;
		@(posedge clk);
		sclk <= 1'b0;
		sdin <= ~sdin; // A stale data level is never left standing.
		repeat (4) @(posedge clk);
	endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the control slice driven by the serial host model.
`timescale 1ns/100ps
module tb_top;
	localparam logic [2:0] PM = asp_pkg::PAGE_MASTER;
	localparam logic [2:0] PA = asp_pkg::PAGE_ADC;
	localparam logic [2:0] PD = asp_pkg::PAGE_DIGITAL;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic sysref_in = 1'b0;
	logic fast_overrange_flag_b_in = 1'b0;
	logic sen_n;
	logic sclk;
	logic sdin;
	logic serial_data_out;
	logic sysref_out;
	logic sysref_hicm;
	logic pdn1;
	logic pdn2;
	logic [3:0] perf;
	logic [7:0] thr;
	logic app_v;
	logic [7:0] app_a;
	logic [7:0] app_d;
	logic [7:0] applied [256];
	int apply_cnt = 0;
	int err_count = 0;
	int compares = 0;

	// ==========================================================
	// Clock, design and host
	// ==========================================================
	// Half period of 50 ns gives the 10 MHz clock.
	always #50 clock = ~clock;
	asp_ctrl_regs i_dut (.CLOCK(clock), .NRST(nrst), .SEN_N(sen_n), .SCLK(sclk), .SDIN(sdin),
		.SERIAL_DATA_OUT(serial_data_out), .SYSREF_IN(sysref_in), .FAST_OVERRANGE_FLAG_B_IN(fast_overrange_flag_b_in), .SYSREF_OUT(sysref_out),
		.SYSREF_HICM(sysref_hicm), .PDN_MASK1_EN(pdn1), .PDN_MASK2_EN(pdn2), .PERF_SETTING(perf),
		.FAST_OVERRANGE_FLAG_THRESHOLD(thr), .DIG_APPLY_VALID(app_v), .DIG_APPLY_ADDR(app_a),
		.DIG_APPLY_DATA(app_d));
	asp_host_model i_host (.clk(clock), .sen_n(sen_n), .sclk(sclk), .sdin(sdin), .serial_data_out(serial_data_out));
	// Records each applied byte so the replay is judged after it ends.
	always @(posedge clock) begin
		if (app_v === 1'b1) begin
			applied[app_a] = app_d;
			apply_cnt++;
		end
	end

	// ==========================================================
	// Helpers
	// ==========================================================
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wp(input logic [2:0] pg, input logic [7:0] o, input logic [7:0] d);
		logic [7:0] unused;
		i_host.xfer(1'b0, pg, o, d, unused);
	endtask
	task automatic rp(input logic [2:0] pg, input logic [7:0] o, input logic [7:0] exp,
		input string what);
		logic [7:0] got;
		i_host.xfer(1'b1, pg, o, 8'h00, got);
		check(what, exp, got);
	endtask
	task automatic settle();
		repeat (6) @(posedge clock);
	endtask
	task automatic print_verdict();
		$display("Checks %0d, errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	// Reset values, including an unmapped offset and a write-only register.
	task automatic t_reset();
		logic [7:0] ofs [7] = '{8'h53, 8'h54, 8'h55, 8'h56, 8'h59, 8'h26, 8'h10};
		check("idle outputs", 8'h00, {sysref_out, sysref_hicm, pdn1, pdn2, perf});
		check("threshold", 8'h00, thr);
		foreach (ofs[i]) rp(PM, ofs[i], 8'h00, "reset read");
		rp(PA, 8'h5F, 8'h00, "threshold read");
	endtask
	// The ignore bit, the soft level under manual control and the receiver setting.
	task automatic t_sysref();
		sysref_in <= 1'b1;
		wp(PM, 8'h53, 8'h40);
		settle();
		check("ignored sysref", 8'h00, {7'h00, sysref_out});
		wp(PM, 8'h53, 8'h02);
		settle();
		check("sysref path", 8'h03, {6'h00, sysref_hicm, sysref_out});
		sysref_in <= 1'b0;
		settle();
		check("sysref low", 8'h02, {6'h00, sysref_hicm, sysref_out});
		rp(PM, 8'h53, 8'h02, "sysref read");
		wp(PM, 8'h54, 8'h80);
		wp(PM, 8'h53, 8'h41);
		check("soft high", 8'h01, {7'h00, sysref_out});
		rp(PM, 8'h54, 8'h80, "manual read");
		wp(PM, 8'h53, 8'h40);
		check("soft low", 8'h00, {7'h00, sysref_out});
		wp(PM, 8'h54, 8'h00);
	endtask
	// Register power-down through each mask in turn.
	task automatic t_pdn();
		wp(PM, 8'h55, 8'h10);
		check("mask one", 8'h02, {6'h00, pdn1, pdn2});
		wp(PM, 8'h26, 8'h20);
		check("mask two", 8'h01, {6'h00, pdn1, pdn2});
		rp(PM, 8'h55, 8'h10, "pdn read");
		wp(PM, 8'h55, 8'h00);
		check("mask off", 8'h00, {6'h00, pdn1, pdn2});
		wp(PM, 8'h26, 8'h00);
	endtask
	// The split performance field, written as a whole each time.
	task automatic t_perf();
		wp(PM, 8'h39, 8'hC0);
		wp(PM, 8'h3A, 8'h40);
		wp(PM, 8'h56, 8'h04);
		check("perf all", 8'h0F, {4'h0, perf});
		rp(PM, 8'h56, 8'h00, "perf high read");
		wp(PM, 8'h39, 8'h40);
		wp(PM, 8'h3A, 8'h00);
		wp(PM, 8'h56, 8'h04);
		check("perf mixed", 8'h09, {4'h0, perf});
	endtask
	// Overrange routing onto the serial output, then back to normal.
	task automatic t_route();
		fast_overrange_flag_b_in <= 1'b1;
		wp(PM, 8'h59, 8'hA0);
		settle();
		check("route high", 8'h01, {7'h00, serial_data_out});
		fast_overrange_flag_b_in <= 1'b0;
		settle();
		check("route low", 8'h00, {7'h00, serial_data_out});
		fast_overrange_flag_b_in <= 1'b1;
		wp(PM, 8'h59, 8'h20);
		settle();
		check("route off", 8'h00, {7'h00, serial_data_out});
		rp(PM, 8'h59, 8'h20, "route read");
	endtask
	// One threshold byte shared by both channels.
	task automatic t_thr();
		wp(PA, 8'h5F, 8'hA5);
		check("threshold", 8'hA5, thr);
		rp(PA, 8'h5F, 8'hA5, "threshold read");
	endtask
	// Staged digital page bytes apply only after the commit pulse.
	task automatic t_commit();
		int base;
		base = apply_cnt;
		wp(PD, 8'h01, 8'h3C);
		wp(PD, 8'h41, 8'h5A);
		rp(PD, 8'h41, 8'h5A, "staged read");
		check("early apply", 8'h00, 8'(apply_cnt - base));
		wp(PD, 8'h00, 8'h00);
		wp(PD, 8'h00, 8'h01);
		rp(PD, 8'h00, 8'h01, "pulse read");
		check("apply before fall", 8'h00, 8'(apply_cnt - base));
		wp(PD, 8'h00, 8'h00);
		for (int n = 0; n < 400 && apply_cnt - base < 255; n++) @(posedge clock);
		check("applied count", 8'hFF, 8'(apply_cnt - base));
		check("applied 01", 8'h3C, applied[8'h01]);
		check("applied 41", 8'h5A, applied[8'h41]);
		check("applied 02", 8'h00, applied[8'h02]);
	endtask
	// A reset in mid-run must return the performance field, the threshold and a staged byte to their idle values.
	task automatic t_midreset();
		nrst <= 1'b0;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		repeat (5) @(posedge clock);
		check("reset perf", 8'h00, {4'h0, perf});
		check("reset threshold", 8'h00, thr);
		rp(PA, 8'h5F, 8'h00, "reset threshold read");
		rp(PD, 8'h41, 8'h00, "reset staged read");
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	// Reset for 20 cycles, a short gap for the synchronisers, then every scenario.
	initial begin
		foreach (applied[i]) applied[i] = 8'h00;
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		repeat (5) @(posedge clock);
		t_reset();
		t_sysref();
		t_pdn();
		t_perf();
		t_route();
		t_thr();
		t_commit();
		t_midreset();
		print_verdict();
	end
endmodule
